/* rtl/cmc_mode_irq.sv */
/*
 * Mode sequencing (init, sleep, power-down, recovery), wake-up detection
 * and flag/interrupt handling for a CAN controller.
 * Assumes all inputs synchronous to sys_clk; write ports are 1-cycle pulses.
 */
`default_nettype none
module cmc_mode_irq (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic moduleEnable,
    input wire logic cpuStop,
    input wire logic cpuWait,
    input wire logic ctlWrite,
    input wire cmc_pkg::cmc_ctrl_t ctlData,
    input wire logic ierWrite,
    input wire logic [6:0] ierData,
    input wire logic flagClear,
    input wire logic [6:0] flagClearMask,
    input wire logic [2:0] txBufEmpty,
    input wire logic rxShifted,
    input wire logic overrunEvent,
    input wire logic errChange,
    input wire cmc_pkg::cmc_errstate_t errState,
    input wire logic busIdle,
    input wire logic bus_rx_pin,
    input wire logic engineTxBit,
    output logic bus_tx_pin,
    output logic engineHalt,
    output logic clocksRunning,
    output logic cfgWriteEnable,
    output cmc_pkg::cmc_ctrl_t ctrlState,
    output logic init_acknowledge,
    output logic sleep_acknowledge,
    output logic powerDown,
    output logic [6:0] flags,
    output logic [6:0] irqEnables,
    output cmc_pkg::cmc_errstate_t errStateOut,
    output logic wakeupIrq,
    output logic errorIrq,
    output logic rxIrq,
    output logic txIrq
);
    import cmc_pkg::*;

    // Mode group state
    cmc_mode_t modeReg, modeNext;
    cmc_ctrl_t ctrlReg, ctrlNext;
    logic [2:0] syncCntReg, syncCntNext; // Init handshake delay
    logic [3:0] recCntReg, recCntNext; // Recovery delay
    logic [3:0] lowCntReg, lowCntNext; // Dominant duration
    logic sleptReg, sleptNext; // Sleeping before power-down
    logic txPinNext;
    logic wakeSet; // Wake event this cycle
    logic pdReq;

    // Flag group state
    logic [6:0] flagReg, flagNext;
    logic [6:0] ierReg, ierNext;
    logic [6:0] setVec;
    cmc_errstate_t errReg, errNext;
    logic wIrqNext, eIrqNext, rIrqNext, tIrqNext;

    // Power-down request from CPU state
    assign pdReq = cpuStop | (cpuWait & ctrlReg.stopInWait);

    // Mode sequencing and control bits
    always_comb
    begin
        modeNext = modeReg;
        ctrlNext = ctrlReg;
        syncCntNext = syncCntReg;
        recCntNext = recCntReg;
        lowCntNext = lowCntReg;
        sleptNext = sleptReg;
        wakeSet = 1'b0;
        // Dominant-time counter, saturating
        if (bus_rx_pin)
            lowCntNext = 4'h0;
        else if (lowCntReg != 4'hf)
            lowCntNext = lowCntReg + 4'h1;
        // Wake on dominant, filtered when asked
        if (ctrlReg.wakeupEnable && !bus_rx_pin &&
            (!ctrlReg.wakeupFilterMode ||
             lowCntReg >= 4'(WAKE_FILTER_CYCLES - 1)))
        begin
            // Sleep, or power-down entered from sleep
            if (modeReg == MODE_SLEEP)
                wakeSet = 1'b1;
            else if (modeReg == MODE_POWERDOWN && sleptReg &&
                     ierReg[FLAG_WAKE])
                wakeSet = 1'b1;
        end
        // Software control write
        if (ctlWrite)
        begin
            ctrlNext.wakeupEnable = ctlData.wakeupEnable;
            ctrlNext.stopInWait = ctlData.stopInWait;
            ctrlNext.wakeupFilterMode = ctlData.wakeupFilterMode;
            // Sleep request clears only once sleep is active
            if (ctlData.sleepRequest || modeReg == MODE_SLEEP)
                ctrlNext.sleepRequest = ctlData.sleepRequest;
            // Init request clears only once init is active
            if (ctlData.initRequest || modeReg == MODE_INIT)
                ctrlNext.initRequest = ctlData.initRequest;
        end
        // Wake-up drops the sleep request
        if (wakeSet)
            ctrlNext.sleepRequest = 1'b0;
        if (!moduleEnable)
        begin
            // Clocks stopped: everything holds
            modeNext = modeReg;
            ctrlNext = ctrlReg;
            lowCntNext = lowCntReg;
            wakeSet = 1'b0;
        end
        else if (modeReg == MODE_POWERDOWN)
        begin
            // Leave when CPU resumes; recover if not sleeping before
            if (!pdReq)
            begin
                if (!sleptReg)
                    modeNext = MODE_RECOVER;
                else if (ctrlNext.sleepRequest)
                    modeNext = MODE_SLEEP;
                else
                    modeNext = MODE_NORMAL;
                recCntNext = 4'h0;
            end
        end
        else if (pdReq)
        begin
            // Abrupt entry from any running mode
            modeNext = MODE_POWERDOWN;
            sleptNext = (modeReg == MODE_SLEEP);
        end
        else
        begin
            case (modeReg)
                MODE_INIT:
                begin
                    // Sleep, wake-up and stop-in-wait bits back to defaults; filter mode and request kept
                    ctrlNext.sleepRequest = 1'b0;
                    ctrlNext.wakeupEnable = 1'b0;
                    ctrlNext.stopInWait = 1'b0;
                    if (!ctrlReg.initRequest)
                        modeNext = MODE_NORMAL;
                end
                MODE_RECOVER:
                begin
                    // Fixed internal restart delay
                    if (recCntReg == 4'(RECOVERY_CYCLES - 1))
                        modeNext = MODE_NORMAL;
                    else
                        recCntNext = recCntReg + 4'h1;
                end
                MODE_NORMAL, MODE_SLEEP:
                begin
                    if (ctrlReg.initRequest)
                    begin
                        // Handshake delay before all parts halt
                        if (syncCntReg == 3'(INIT_SYNC_CYCLES - 1))
                        begin
                            modeNext = MODE_INIT;
                            syncCntNext = 3'h0;
                        end
                        else
                            syncCntNext = syncCntReg + 3'h1;
                    end
                    else if (modeReg == MODE_SLEEP)
                    begin
                        if (!ctrlNext.sleepRequest)
                            modeNext = MODE_NORMAL;
                    end
                    // Sleep once bus idle and no transmit pending
                    else if (ctrlReg.sleepRequest && busIdle &&
                             &txBufEmpty)
                        modeNext = MODE_SLEEP;
                end
                default: modeNext = MODE_NORMAL;
            endcase
        end
        // Transmit pin recessive whenever the next mode is not normal
        txPinNext = (modeNext == MODE_NORMAL) ? engineTxBit : 1'b1;
    end

    // Mode group registers and registered outputs
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // Out of reset the block sits in init mode
            modeReg <= MODE_INIT;
            ctrlReg <= '{initRequest: 1'b1, default: 1'b0};
            syncCntReg <= 3'h0;
            recCntReg <= 4'h0;
            lowCntReg <= 4'h0;
            sleptReg <= 1'b0;
            bus_tx_pin <= 1'b1;
            engineHalt <= 1'b1;
            clocksRunning <= 1'b0;
            cfgWriteEnable <= 1'b1;
            init_acknowledge <= 1'b1;
            sleep_acknowledge <= 1'b0;
            powerDown <= 1'b0;
        end
        else
        begin
            modeReg <= modeNext;
            ctrlReg <= ctrlNext;
            syncCntReg <= syncCntNext;
            recCntReg <= recCntNext;
            lowCntReg <= lowCntNext;
            sleptReg <= sleptNext;
            bus_tx_pin <= txPinNext;
            engineHalt <= (modeNext != MODE_NORMAL) || !moduleEnable;
            clocksRunning <= moduleEnable &&
                             (modeNext != MODE_POWERDOWN);
            cfgWriteEnable <= (modeNext == MODE_INIT);
            init_acknowledge <= (modeNext == MODE_INIT);
            sleep_acknowledge <= (modeNext == MODE_SLEEP);
            powerDown <= (modeNext == MODE_POWERDOWN);
        end
    end

    assign ctrlState = ctrlReg;

    // Flag set sources
    assign setVec = {~txBufEmpty == 3'h0 ? 3'h7 : txBufEmpty,
                     rxShifted, overrunEvent, errChange, wakeSet};

    // One write-one-to-clear flag per bit
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_COUNT; gi++)
        begin : g_flag
            // Set wins; clear only on a one and absent condition
            assign flagNext[gi] =
                (modeNext == MODE_INIT) ? FLAG_RESET[gi] :
                (!moduleEnable || modeReg == MODE_POWERDOWN) ?
                    (flagReg[gi] | (moduleEnable & setVec[gi])) :
                setVec[gi] | (flagReg[gi] &
                    ~(flagClear & flagClearMask[gi]));
        end
    endgenerate

    // Enables, error status and interrupt lines
    always_comb
    begin
        ierNext = ierReg;
        errNext = errReg;
        if (ierWrite)
            ierNext = ierData;
        if (errChange)
            errNext = errState;
        if (modeNext == MODE_INIT)
            ierNext = ENABLE_RESET;
        // Each source gated by its own enables
        wIrqNext = flagNext[FLAG_WAKE] & ierNext[FLAG_WAKE];
        eIrqNext = |(flagNext[2:1] & ierNext[2:1]);
        rIrqNext = flagNext[FLAG_RXFULL] & ierNext[FLAG_RXFULL];
        tIrqNext = |(flagNext[6:4] & ierNext[6:4]);
    end

    // Flag group registers
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flagReg <= FLAG_RESET;
            ierReg <= ENABLE_RESET;
            errReg <= '0;
            wakeupIrq <= 1'b0;
            errorIrq <= 1'b0;
            rxIrq <= 1'b0;
            txIrq <= 1'b0;
        end
        else
        begin
            flagReg <= flagNext;
            ierReg <= ierNext;
            errReg <= errNext;
            wakeupIrq <= wIrqNext;
            errorIrq <= eIrqNext;
            rxIrq <= rIrqNext;
            txIrq <= tIrqNext;
        end
    end

    assign flags = flagReg;
    assign irqEnables = ierReg;
    assign errStateOut = errReg;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_initTx;
        init_acknowledge |-> bus_tx_pin && engineHalt;
    endproperty
    a_initTx: assert property (p_initTx)
        else $error("tx pin not recessive in init");

    property p_initDelay;
        $rose(init_acknowledge) |-> $past(ctrlReg.initRequest, 4);
    endproperty
    a_initDelay: assert property (p_initDelay)
        else $error("init acknowledged too early");

    property p_initHold;
        ctlWrite && !ctlData.initRequest && ctrlReg.initRequest &&
            modeReg != MODE_INIT |=> ctrlReg.initRequest;
    endproperty
    a_initHold: assert property (p_initHold)
        else $error("init request cleared before acknowledge");

    property p_cfgLock;
        cfgWriteEnable |-> init_acknowledge && engineHalt;
    endproperty
    a_cfgLock: assert property (p_cfgLock)
        else $error("config writable outside init");

    property p_pdTx;
        powerDown |-> bus_tx_pin && !clocksRunning;
    endproperty
    a_pdTx: assert property (p_pdTx)
        else $error("power-down with live pin or clocks");

    property p_setWins;
        rxShifted && moduleEnable && modeReg != MODE_POWERDOWN &&
            modeNext != MODE_INIT |=> flags[FLAG_RXFULL] ##1 rxIrq ==
            (flags[FLAG_RXFULL] && ierReg[FLAG_RXFULL]);
    endproperty
    a_setWins: assert property (p_setWins)
        else $error("receive flag lost on set");

    property p_zeroWrite;
        flagClear && !flagClearMask[FLAG_STATUS] && flags[FLAG_STATUS] &&
            modeNext != MODE_INIT |=> flags[FLAG_STATUS];
    endproperty
    a_zeroWrite: assert property (p_zeroWrite)
        else $error("flag changed by zero write");

    property p_sleepAck;
        sleep_acknowledge |-> ctrlReg.sleepRequest;
    endproperty
    a_sleepAck: assert property (p_sleepAck)
        else $error("sleep acknowledge without request");

    property p_wakeCause;
        $rose(flags[FLAG_WAKE]) |-> $past(ctrlReg.wakeupEnable) &&
            !$past(bus_rx_pin);
    endproperty
    a_wakeCause: assert property (p_wakeCause)
        else $error("wake flag without enabled activity");

    property p_recover;
        modeReg == MODE_RECOVER && recCntReg == 4'h0 |->
            modeReg == MODE_RECOVER [*7];
    endproperty
    a_recover: assert property (p_recover)
        else $error("recovery cycle too short");

    c_init: cover property ($fell(init_acknowledge));
    c_sleep: cover property ($rose(sleep_acknowledge));
    c_recover: cover property (modeReg == MODE_RECOVER ##1
                               modeReg == MODE_NORMAL);
    c_wake: cover property ($rose(wakeupIrq));
endmodule : cmc_mode_irq
`default_nettype wire

/* rtl/cmc_pkg.sv */
/*
 * Constants and carrier types for the CAN mode and interrupt control block.
 * Assumes a single 100 MHz system clock and plain-port register access.
 */
`default_nettype none
package cmc_pkg;
    // Clock period in ns
    localparam int CLK_PERIOD_NS = 10;
    // Init handshake delay, bus plus CAN clocks
    localparam int INIT_SYNC_BUS_CLKS = 2;
    localparam int INIT_SYNC_CAN_CLKS = 3;
    localparam int INIT_SYNC_CYCLES = INIT_SYNC_BUS_CLKS + INIT_SYNC_CAN_CLKS;
    // Fixed recovery delay after unplanned power-down
    localparam int RECOVERY_CYCLES = 8;
    // Wake-up glitch filter: shortest accepted dominant time
    localparam int WAKE_FILTER_NS = 100;
    localparam int WAKE_FILTER_CYCLES =
        (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Flag and enable bit positions
    localparam int FLAG_WAKE = 0;
    localparam int FLAG_STATUS = 1;
    localparam int FLAG_OVERRUN = 2;
    localparam int FLAG_RXFULL = 3;
    localparam int FLAG_TXE0 = 4;
    localparam int FLAG_COUNT = 7;
    // Flag defaults: transmit buffers empty, rest clear
    localparam logic [6:0] FLAG_RESET = 7'h70;
    localparam logic [6:0] ENABLE_RESET = 7'h00;
    // Operating modes
    typedef enum logic [2:0] {
        MODE_NORMAL, MODE_SLEEP, MODE_INIT, MODE_POWERDOWN, MODE_RECOVER
    } cmc_mode_t;
    // Control word written by software
    typedef struct packed {
        logic initRequest;
        logic sleepRequest;
        logic wakeupEnable;
        logic stopInWait;
        logic wakeupFilterMode;
    } cmc_ctrl_t;
    // Error state report from the protocol engine
    typedef struct packed {
        logic [1:0] txState;
        logic [1:0] rxState;
    } cmc_errstate_t;
endpackage : cmc_pkg
`default_nettype wire

/* sim/cmc_bus_model.sv */
/*
 * Far-side model of the CAN bus as a wired-AND line with one other node.
 * Assumes the bench calls dominant() just after a rising sys_clk edge.
 */
`default_nettype none
module cmc_bus_model (
    input wire logic sys_clk,
    input wire logic bus_tx_pin,
    output logic bus_rx_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // Other node pulling the line dominant
    logic otherDom = 1'h0;
    // Wired-AND: line recessive unless some node drives it low
    assign bus_rx_pin = bus_tx_pin & ~otherDom;
    // Dominant stretch for len edges, then released to recessive
    task automatic dominant(input int len);
        otherDom = 1'h1;
        repeat (len)
            @(posedge sys_clk);
        #1;
        otherDom = 1'h0;
    endtask : dominant
endmodule : cmc_bus_model
`default_nettype wire

/* sim/cmc_mode_irq_tb.sv */
/*
 * Self-checking bench for cmc_mode_irq: init, sleep, wake, power-down,
 * flags and masking. Assumes cmc_pkg and cmc_bus_model are compiled first.
 */
`default_nettype none
module cmc_mode_irq_tb;
    import cmc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    // Design stimulus and observation
    logic sys_clk, rst_b, moduleEnable, cpuStop, cpuWait, ctlWrite;
    cmc_ctrl_t ctlData, ctrlState;
    cmc_errstate_t errState, errStateOut;
    logic ierWrite, flagClear, rxShifted, overrunEvent, errChange;
    logic busIdle, bus_rx_pin, engineTxBit, bus_tx_pin, engineHalt;
    logic clocksRunning, cfgWriteEnable, init_acknowledge;
    logic sleep_acknowledge, powerDown, wakeupIrq, errorIrq, rxIrq, txIrq;
    logic [6:0] ierData, flagClearMask, flags, irqEnables, ef;
    logic [2:0] txBufEmpty;
    // Counters for the verdict
    int errTotal = 0;
    int cmpCount = 0;
    int n;
    // 100 MHz clock
    initial
    begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    cmc_mode_irq dut_u (
        .sys_clk(sys_clk), .rst_b(rst_b), .moduleEnable(moduleEnable),
        .cpuStop(cpuStop), .cpuWait(cpuWait), .ctlWrite(ctlWrite),
        .ctlData(ctlData), .ierWrite(ierWrite), .ierData(ierData),
        .flagClear(flagClear), .flagClearMask(flagClearMask),
        .txBufEmpty(txBufEmpty), .rxShifted(rxShifted),
        .overrunEvent(overrunEvent), .errChange(errChange),
        .errState(errState), .busIdle(busIdle), .bus_rx_pin(bus_rx_pin),
        .engineTxBit(engineTxBit), .bus_tx_pin(bus_tx_pin),
        .engineHalt(engineHalt), .clocksRunning(clocksRunning),
        .cfgWriteEnable(cfgWriteEnable), .ctrlState(ctrlState),
        .init_acknowledge(init_acknowledge),
        .sleep_acknowledge(sleep_acknowledge), .powerDown(powerDown),
        .flags(flags), .irqEnables(irqEnables), .errStateOut(errStateOut),
        .wakeupIrq(wakeupIrq), .errorIrq(errorIrq), .rxIrq(rxIrq),
        .txIrq(txIrq)
    );
    cmc_bus_model bus_u (
        .sys_clk(sys_clk), .bus_tx_pin(bus_tx_pin), .bus_rx_pin(bus_rx_pin)
    );
    // Advance k edges, landing just after the last one
    task automatic tick(input int k);
        repeat (k)
        begin
            @(posedge sys_clk);
            #1;
        end
    endtask : tick
    // Verdict and end of run
    task automatic giveVerdict();
        if (errTotal == 0 && cmpCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : giveVerdict
    task automatic bad(input string m);
        errTotal++;
        $display("BAD %0t %s", $time, m);
    endtask : bad
    // Single-bit compare
    task automatic chkBit(input logic g, input logic e, input string m);
        cmpCount++;
        if (g !== e)
            bad(m);
    endtask : chkBit
    // Vector compare
    task automatic chkVec(input logic [6:0] g, e, input string m);
        cmpCount++;
        if (g !== e)
            bad(m);
    endtask : chkVec
    // Bounded wait for a level; running out ends the run
    task automatic waitFor(ref logic s, input logic v, output int k);
        for (k = 0; s !== v; k++)
        begin
            if (k == 200)
            begin
                bad("wait timed out");
                giveVerdict();
            end
            tick(1);
        end
    endtask : waitFor
    // Control word write: init, sleep, wake, stop-in-wait, filter
    task automatic wrCtl(input logic ir, sr, we, sw, fm);
        ctlData = '{ir, sr, we, sw, fm};
        ctlWrite = 1'h1;
        tick(1);
        ctlWrite = 1'h0;
    endtask : wrCtl
    task automatic wrIer(input logic [6:0] v);
        ierData = v;
        ierWrite = 1'h1;
        tick(1);
        ierWrite = 1'h0;
    endtask : wrIer
    task automatic clrFlags(input logic [6:0] m);
        flagClearMask = m;
        flagClear = 1'h1;
        tick(1);
        flagClear = 1'h0;
    endtask : clrFlags
    // Reset state, then the start-up exit to normal
    task automatic tResetExit();
        chkBit(init_acknowledge, 1'h1, "init ack after reset");
        chkBit(bus_tx_pin, 1'h1, "tx recessive in init");
        chkVec(flags, FLAG_RESET, "flag defaults");
        chkVec(irqEnables, ENABLE_RESET, "enable defaults");
        wrCtl(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        tick(1);
        chkBit(init_acknowledge, 1'h0, "init exit");
        chkBit(cfgWriteEnable, 1'h0, "config locked in normal");
    endtask : tResetExit
    // Flag set, clear, hold and masking
    task automatic tFlags();
        wrIer(7'h7f);
        txBufEmpty = 3'h6;
        clrFlags(7'h30);
        chkVec(flags, 7'h60, "tx clear vs held");
        chkBit(txIrq, 1'h1, "tx irq pending");
        rxShifted = 1'h1;
        tick(1);
        rxShifted = 1'h0;
        chkBit(rxIrq, 1'h1, "rx full irq");
        overrunEvent = 1'h1;
        errChange = 1'h1;
        errState = 4'hb;
        tick(1);
        overrunEvent = 1'h0;
        errChange = 1'h0;
        chkVec(flags, 7'h6e, "error flags");
        chkVec({3'h0, errStateOut}, 7'h0b, "error state");
        clrFlags(7'h00);
        chkVec(flags, 7'h6e, "zero mask");
        tick(1);
        clrFlags(7'h08);
        chkVec(flags, 7'h66, "single clear");
        wrIer(7'h00);
        tick(1);
        chkVec({3'h0, wakeupIrq, errorIrq, rxIrq, txIrq}, 7'h0, "mask");
        wrIer(7'h04);
        tick(1);
        chkVec({3'h0, wakeupIrq, errorIrq, rxIrq, txIrq}, 7'h4, "err");
        wrIer(7'h40);
        tick(1);
        chkVec({3'h0, wakeupIrq, errorIrq, rxIrq, txIrq}, 7'h1, "tx2");
        txBufEmpty = 3'h7;
    endtask : tFlags
    // Init entry timing, defaults, refused early clear
    task automatic tInit();
        engineTxBit = 1'h0;
        tick(2);
        chkBit(bus_tx_pin, 1'h0, "tx follows engine");
        // Quiesce through sleep before asking for init
        wrCtl(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
        waitFor(sleep_acknowledge, 1'h1, n);
        wrCtl(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
        waitFor(init_acknowledge, 1'h1, n);
        chkVec(7'(n), 7'(INIT_SYNC_CYCLES), "init sync delay");
        chkBit(bus_tx_pin, 1'h1, "tx recessive in init");
        chkBit(cfgWriteEnable, 1'h1, "config open");
        chkBit(engineHalt, 1'h1, "stopped in init");
        chkVec(flags, FLAG_RESET, "flags defaulted");
        chkVec(irqEnables, ENABLE_RESET, "enables defaulted");
        wrCtl(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        engineTxBit = 1'h1;
        tick(1);
        wrCtl(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
        tick(1);
        wrCtl(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        chkBit(ctrlState.initRequest, 1'h1, "early clear refused");
        waitFor(init_acknowledge, 1'h1, n);
        wrCtl(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        tick(1);
        chkBit(init_acknowledge, 1'h0, "back to normal");
    endtask : tInit
    // Sleep, wake by bus activity, glitch filter, wake disabled
    task automatic tSleep();
        wrIer(7'h01);
        wrCtl(1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
        waitFor(sleep_acknowledge, 1'h1, n);
        chkBit(ctrlState.sleepRequest, 1'h1, "sleep shown");
        chkBit(engineHalt, 1'h1, "halted in sleep");
        bus_u.dominant(2);
        waitFor(sleep_acknowledge, 1'h0, n);
        chkBit(flags[FLAG_WAKE], 1'h1, "wake flag");
        chkBit(wakeupIrq, 1'h1, "wake irq");
        clrFlags(7'h01);
        wrCtl(1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
        waitFor(sleep_acknowledge, 1'h1, n);
        bus_u.dominant(WAKE_FILTER_CYCLES - 5);
        tick(3);
        chkBit(sleep_acknowledge, 1'h1, "glitch rejected");
        bus_u.dominant(WAKE_FILTER_CYCLES + 2);
        waitFor(sleep_acknowledge, 1'h0, n);
        chkBit(flags[FLAG_WAKE], 1'h1, "filtered wake");
        clrFlags(7'h01);
        wrCtl(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
        waitFor(sleep_acknowledge, 1'h1, n);
        bus_u.dominant(3);
        tick(2);
        chkBit(flags[FLAG_WAKE], 1'h0, "wake disabled");
        chkBit(sleep_acknowledge, 1'h1, "still asleep");
        wrCtl(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        waitFor(sleep_acknowledge, 1'h0, n);
    endtask : tSleep
    // Power-down entry, recovery, and wake-up from stop
    task automatic tPower();
        engineTxBit = 1'h0;
        cpuWait = 1'h1;
        tick(3);
        chkBit(powerDown, 1'h0, "wait alone");
        cpuWait = 1'h0;
        wrCtl(1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
        cpuWait = 1'h1;
        tick(2);
        chkBit(powerDown, 1'h1, "stop-in-wait");
        chkBit(bus_tx_pin, 1'h1, "tx recessive");
        chkBit(clocksRunning, 1'h0, "clocks stopped");
        cpuWait = 1'h0;
        waitFor(powerDown, 1'h0, n);
        waitFor(engineHalt, 1'h0, n);
        chkBit(n >= RECOVERY_CYCLES - 1 && n <= RECOVERY_CYCLES + 2,
            1'h1, "recovery length");
        engineTxBit = 1'h1;
        wrCtl(1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
        waitFor(sleep_acknowledge, 1'h1, n);
        cpuStop = 1'h1;
        tick(2);
        chkBit(powerDown, 1'h1, "stop");
        bus_u.dominant(3);
        waitFor(wakeupIrq, 1'h1, n);
        clrFlags(7'h01);
        chkBit(wakeupIrq, 1'h1, "clear ignored, woken");
        cpuStop = 1'h0;
        waitFor(sleep_acknowledge, 1'h0, n);
        clrFlags(7'h01);
    endtask : tPower
    // Module disable freezes state
    task automatic tDisable();
        moduleEnable = 1'h0;
        tick(1);
        chkBit(clocksRunning, 1'h0, "clocks off");
        ef = flags;
        rxShifted = 1'h1;
        tick(1);
        rxShifted = 1'h0;
        tick(1);
        chkVec(flags, ef, "frozen");
        moduleEnable = 1'h1;
        tick(2);
        chkBit(clocksRunning, 1'h1, "clocks on");
    endtask : tDisable
    // Main sequence
    initial
    begin
        {rst_b, cpuStop, cpuWait, ctlWrite, ierWrite, flagClear} = '0;
        {rxShifted, overrunEvent, errChange} = '0;
        {ctlData, errState, ierData, flagClearMask} = '0;
        {moduleEnable, busIdle, engineTxBit} = 3'h7;
        txBufEmpty = 3'h7;
        tick(5);
        rst_b = 1'h1;
        tResetExit();
        tFlags();
        tInit();
        tSleep();
        tPower();
        tDisable();
        giveVerdict();
    end
endmodule : cmc_mode_irq_tb
`default_nettype wire
